// [src/bsdp_acc_if.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bsdp_regs.svh"
interface bsdp_acc_if;
	logic [`BSDP_PORTS-1:0]                        en;
	logic [`BSDP_PORTS-1:0]                        we;
	logic [`BSDP_PORTS-1:0][`BSDP_LANES-1:0]       be;
	logic [`BSDP_PORTS-1:0][`BSDP_ADDR_W-1:0]      addr;
	logic [`BSDP_PORTS-1:0][`BSDP_DATA_W-1:0]      wdata;
	logic [`BSDP_PORTS-1:0][`BSDP_DATA_W-1:0]      rdata;
	logic                                          clash;
	modport ctl (output en, we, be, addr, wdata, input rdata, clash);
	modport mem (input en, we, be, addr, wdata, output rdata, clash);
endinterface : bsdp_acc_if
`default_nettype wire

// [src/bsdp_addr_ctr.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bsdp_regs.svh"
module bsdp_addr_ctr (
	input  wire logic                      clock_i,
	input  wire logic                      reset_i,
	input  wire logic [`BSDP_ADDR_W-1:0]   ext_addr_i,
	input  wire logic                      address_strobe_load_n_i,
	input  wire logic                      counter_advance_enable_n_i,
	input  wire logic                      counter_reload_n_i,
	output var  logic [`BSDP_ADDR_W-1:0]   addr_o
);
	logic [`BSDP_ADDR_W-1:0] addr_q;
	logic [`BSDP_ADDR_W-1:0] addr_d;
	logic [`BSDP_ADDR_W-1:0] last_load_q;
	bsdp_pkg::bsdp_asrc_t    src;

	// Strobe outranks reload, reload outranks advance
	assign src = !address_strobe_load_n_i ? bsdp_pkg::BSDP_ASRC_LOAD :
		!counter_reload_n_i ? bsdp_pkg::BSDP_ASRC_RELOAD :
		!counter_advance_enable_n_i ? bsdp_pkg::BSDP_ASRC_ADVANCE : bsdp_pkg::BSDP_ASRC_HOLD;

	always_comb begin
		case (src)
			bsdp_pkg::BSDP_ASRC_LOAD:    addr_d = ext_addr_i;
			bsdp_pkg::BSDP_ASRC_RELOAD:  addr_d = last_load_q;
			// Bank bits sit on top, so the carry crosses banks and wraps 63 to 0
			bsdp_pkg::BSDP_ASRC_ADVANCE: addr_d = addr_q + `BSDP_ADDR_W'('h1);
			bsdp_pkg::BSDP_ASRC_HOLD:    addr_d = addr_q;
			default:                     addr_d = addr_q;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			addr_q      <= `BSDP_ADDR_RST;
			last_load_q <= `BSDP_ADDR_RST;
		end else begin
			addr_q <= addr_d;
			if (src == bsdp_pkg::BSDP_ASRC_LOAD) begin
				last_load_q <= ext_addr_i;
			end
		end
	end

	assign addr_o = addr_q;
endmodule : bsdp_addr_ctr
`default_nettype wire

// [src/bsdp_bank_mem.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bsdp_regs.svh"
module bsdp_bank_mem #(
	parameter int BANKS = 64,
	parameter int WORDS = 4096
) (
	input  wire logic clock_i,
	bsdp_acc_if.mem   acc
);
	// One flat array; the bank number is the upper address field
	logic [`BSDP_DATA_W-1:0] mem_q [0:BANKS*WORDS-1];

	// Same bank on both ports: both writes are void; reads still return data
	assign acc.clash = acc.en[0] & acc.en[1] &
		(acc.addr[0][`BSDP_ADDR_W-1:`BSDP_OFS_W] == acc.addr[1][`BSDP_ADDR_W-1:`BSDP_OFS_W]);

	genvar p;
	generate
		for (p = 0; p < `BSDP_PORTS; p++) begin : g_rd
			// Read is combinational here; the port registers it, so a write lands before the next read
			assign acc.rdata[p] = mem_q[acc.addr[p]];
		end
	endgenerate

	always_ff @(posedge clock_i) begin
		for (int q = 0; q < `BSDP_PORTS; q++) begin
			for (int l = 0; l < `BSDP_LANES; l++) begin
				// Different banks never interact, so both ports may write in one edge
				if (acc.en[q] && acc.we[q] && acc.be[q][l] && !acc.clash) begin
					mem_q[acc.addr[q]][l*`BSDP_LANE_W +: `BSDP_LANE_W] <=
						acc.wdata[q][l*`BSDP_LANE_W +: `BSDP_LANE_W];
				end
			end
		end
	end
endmodule : bsdp_bank_mem
`default_nettype wire

// [src/bsdp_dual_port.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bsdp_regs.svh"
module bsdp_dual_port #(
	parameter int BANKS = 64,
	parameter int WORDS = 4096
) (
	input  wire logic                                         clock_i,
	input  wire logic                                         reset_i,
	input  wire logic [`BSDP_PORTS-1:0][`BSDP_BANK_W-1:0]      bank_number_inputs_i,
	input  wire logic [`BSDP_PORTS-1:0][`BSDP_OFS_W-1:0]       offset_i,
	input  wire logic [`BSDP_PORTS-1:0]                        address_strobe_load_n_i,
	input  wire logic [`BSDP_PORTS-1:0]                        counter_advance_enable_n_i,
	input  wire logic [`BSDP_PORTS-1:0]                        counter_reload_n_i,
	input  wire logic [`BSDP_PORTS-1:0]                        chip_select_low_active_n_i,
	input  wire logic [`BSDP_PORTS-1:0]                        chip_select_high_active_i,
	input  wire logic [`BSDP_PORTS-1:0][`BSDP_LANES-1:0]       byte_lane_enable_n_i,
	input  wire logic [`BSDP_PORTS-1:0]                        read_write_i,
	input  wire logic [`BSDP_PORTS-1:0]                        output_enable_n_i,
	input  wire logic [`BSDP_PORTS-1:0]                        output_latency_select_i,
	input  wire logic [`BSDP_PORTS-1:0][`BSDP_DATA_W-1:0]      data_i,
	output var  logic [`BSDP_PORTS-1:0][`BSDP_DATA_W-1:0]      data_o,
	output var  logic [`BSDP_PORTS-1:0][`BSDP_DATA_W-1:0]      data_oe_o,
	output var  logic [`BSDP_PORTS-1:0]                        bank_clash_o
);
	bsdp_acc_if acc ();

	bsdp_bank_mem #(
		.BANKS (BANKS),
		.WORDS (WORDS)
	) u_mem (
		.clock_i (clock_i),
		.acc     (acc)
	);

	genvar p;
	generate
		for (p = 0; p < `BSDP_PORTS; p++) begin : g_port
			logic                      lat_meta_q;
			logic                      lat_pipe_q;
			logic                      cs_q;
			logic                      cs_prev_q;
			logic                      rd_q;
			logic [`BSDP_LANES-1:0]    lane_q;
			logic [`BSDP_DATA_W-1:0]   din_q;
			logic [`BSDP_ADDR_W-1:0]   int_addr;
			logic                      cs_now;
			logic                      rd_ok;
			logic [`BSDP_LANES-1:0]    drv_now;
			logic [`BSDP_DATA_W-1:0]   stage_data_q;
			logic [`BSDP_LANES-1:0]    stage_drv_q;
			logic                      stage_clash_q;
			logic [`BSDP_DATA_W-1:0]   out_data_q;
			logic [`BSDP_LANES-1:0]    out_drv_q;
			logic                      out_clash_q;
			logic [`BSDP_DATA_W-1:0]   lane_mask;

			bsdp_addr_ctr u_ctr (
				.clock_i                    (clock_i),
				.reset_i                    (reset_i),
				.ext_addr_i                 ({bank_number_inputs_i[p], offset_i[p]}),
				.address_strobe_load_n_i    (address_strobe_load_n_i[p]),
				.counter_advance_enable_n_i (counter_advance_enable_n_i[p]),
				.counter_reload_n_i         (counter_reload_n_i[p]),
				.addr_o                     (int_addr)
			);

			assign cs_now = !chip_select_low_active_n_i[p] && chip_select_high_active_i[p];

			// Latency select is a static strap, still caught through two flops
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					lat_meta_q <= 1'b0;
					lat_pipe_q <= 1'b0;
				end else begin
					lat_meta_q <= output_latency_select_i[p];
					lat_pipe_q <= lat_meta_q;
				end
			end

			// Controls and write data are registered; the access runs in the following cycle
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					cs_q      <= 1'b0;
					cs_prev_q <= 1'b0;
					rd_q      <= 1'b1;
					lane_q    <= `BSDP_LANE_RST;
					din_q     <= `BSDP_DATA_RST;
				end else begin
					cs_q      <= cs_now;
					cs_prev_q <= cs_q;
					rd_q      <= read_write_i[p];
					lane_q    <= ~byte_lane_enable_n_i[p];
					din_q     <= data_i[p];
				end
			end

			// A deselected port issues no access at all
			assign acc.en[p]    = cs_q;
			assign acc.we[p]    = !rd_q;
			assign acc.be[p]    = lane_q;
			assign acc.addr[p]  = int_addr;
			assign acc.wdata[p] = din_q;

			// Coming out of power-down the first selected cycle yields no data
			assign rd_ok   = cs_q && cs_prev_q && rd_q;
			assign drv_now = {`BSDP_LANES{rd_ok}} & lane_q;

			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					stage_data_q  <= `BSDP_DATA_RST;
					stage_drv_q   <= `BSDP_LANE_RST;
					stage_clash_q <= 1'b0;
					out_data_q    <= `BSDP_DATA_RST;
					out_drv_q     <= `BSDP_LANE_RST;
					out_clash_q   <= 1'b0;
				end else begin
					stage_data_q  <= acc.rdata[p];
					stage_drv_q   <= drv_now;
					stage_clash_q <= acc.clash && cs_q;
					// Pipelined mode takes the extra stage, costing one cycle for a faster clock-to-out
					if (lat_pipe_q) begin
						out_data_q  <= stage_data_q;
						out_drv_q   <= stage_drv_q;
						out_clash_q <= stage_clash_q;
					end else begin
						out_data_q  <= acc.rdata[p];
						out_drv_q   <= drv_now;
						out_clash_q <= acc.clash && cs_q;
					end
				end
			end

			for (genvar l = 0; l < `BSDP_LANES; l++) begin : g_lane
				assign lane_mask[l*`BSDP_LANE_W +: `BSDP_LANE_W] = {`BSDP_LANE_W{out_drv_q[l]}};
			end

			assign data_o[p]       = out_data_q;
			// Output enable gates the drivers without waiting for a clock
			assign data_oe_o[p]    = lane_mask & {`BSDP_DATA_W{!output_enable_n_i[p]}};
			assign bank_clash_o[p] = out_clash_q;
		end
	endgenerate
endmodule : bsdp_dual_port
`default_nettype wire

// [src/bsdp_pkg.sv]
package bsdp_pkg;
	typedef enum logic [1:0] {
		BSDP_ASRC_LOAD    = 2'b00,
		BSDP_ASRC_RELOAD  = 2'b01,
		BSDP_ASRC_ADVANCE = 2'b10,
		BSDP_ASRC_HOLD    = 2'b11
	} bsdp_asrc_t;
endpackage : bsdp_pkg

// [src/bsdp_regs.svh]
`ifndef BSDP_REGS_SVH
`define BSDP_REGS_SVH

`define BSDP_PORTS      2
`define BSDP_BANK_W     6
`define BSDP_OFS_W      12
`define BSDP_ADDR_W     18
`define BSDP_DATA_W     36
`define BSDP_LANES      4
`define BSDP_LANE_W     9
`define BSDP_ADDR_RST   18'h00000
`define BSDP_DATA_RST   36'h000000000
`define BSDP_LANE_RST   4'h0

`endif

// [test/bsdp_dual_port_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module bsdp_dual_port_chk (
	input	wire logic		clock_i,
	input	wire logic		reset_i,
	input	wire logic [1:0][5:0]	bank_number_inputs_i,
	input	wire logic [1:0][11:0]	offset_i,
	input	wire logic [1:0]	address_strobe_load_n_i,
	input	wire logic [1:0]	counter_advance_enable_n_i,
	input	wire logic [1:0]	counter_reload_n_i,
	input	wire logic [1:0]	chip_select_low_active_n_i,
	input	wire logic [1:0]	chip_select_high_active_i,
	input	wire logic [1:0][3:0]	byte_lane_enable_n_i,
	input	wire logic [1:0]	read_write_i,
	input	wire logic [1:0]	output_enable_n_i,
	input	wire logic [1:0]	output_latency_select_i,
	input	wire logic [1:0][35:0]	data_i,
	input	wire logic [1:0][35:0]	data_o,
	input	wire logic [1:0][35:0]	data_oe_o,
	input	wire logic [1:0]	bank_clash_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	wire logic [1:0]	sel = ~chip_select_low_active_n_i & chip_select_high_active_i;
	wire logic [1:0]	rd = sel & read_write_i;
	wire logic	same = bank_number_inputs_i[0] == bank_number_inputs_i[1];
	wire logic	ld2 = ~|address_strobe_load_n_i;
	// Other port must not write, or the held word may legally change
	wire logic	hold0 = rd[0] & address_strobe_load_n_i[0] & counter_advance_enable_n_i[0]
		& counter_reload_n_i[0] & ~|byte_lane_enable_n_i[0] & ~(sel[1] & ~read_write_i[1]);
	a_oe_async: assert property (output_enable_n_i[0] |-> data_oe_o[0] == '0) else $error("oe gate");
	a_desel_flow: assert property (!sel[0] |-> ##2 data_oe_o[0] == '0 ##1 data_oe_o[0] == '0)
		else $error("deselect drive");
	a_desel_pipe: assert property (!sel[1] |-> ##3 data_oe_o[1] == '0 ##1 data_oe_o[1] == '0)
		else $error("pipe deselect drive");
	a_lane_off: assert property (byte_lane_enable_n_i[0][2] |-> ##2 data_oe_o[0][26:18] == '0)
		else $error("lane drive");
	a_write_float: assert property (!read_write_i[0] |-> ##2 data_oe_o[0] == '0) else $error("write drive");
	a_drive_flow: assert property (rd[0] && $past(sel[0]) && byte_lane_enable_n_i[0] == '0
		|-> ##2 (output_enable_n_i[0] || data_oe_o[0] == '1)) else $error("flow drive");
	a_drive_pipe: assert property (rd[1] && $past(sel[1]) && byte_lane_enable_n_i[1] == '0
		|-> ##3 (output_enable_n_i[1] || data_oe_o[1] == '1)) else $error("pipe drive");
	a_hold_out: assert property (hold0[*3] |-> ##2 $stable(data_o[0])) else $error("hold data");
	a_clash_set: assert property (ld2 && rd == 2'b11 && $past(sel) == 2'b11 && same
		|-> ##2 bank_clash_o[0]) else $error("clash missed");
	a_clash_free: assert property (ld2 && !same |-> ##2 !bank_clash_o[0]) else $error("false clash");
	c_flow_read: cover property (rd[0] ##2 data_oe_o[0] == '1);
	c_hold: cover property (hold0[*3]);
	c_clash: cover property (bank_clash_o[1]);
	c_reload: cover property (sel[0] && !counter_reload_n_i[0]);
endmodule : bsdp_dual_port_chk
bind bsdp_dual_port bsdp_dual_port_chk u_chk (.*);
`default_nettype wire

// [test/bsdp_dual_port_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module bsdp_dual_port_bench;
	logic	clock_i = 1'b0;
	logic	reset_i = 1'b1;
	logic [1:0]	oe_n = 2'b00;
	logic [1:0]	rld_n = 2'b11;
	logic [1:0]	cs_hi = 2'b11;
	int	err_total = 0;
	int	compares = 0;
	int	cycles = 0;
	wire logic [1:0][17:0]	a;
	wire logic [1:0]	s_n, c_n, sel, rw, clash;
	wire logic [1:0][3:0]	l_n;
	wire logic [1:0][35:0]	wd, q, qe;
	initial forever #2 clock_i = ~clock_i;
	for (genvar p = 0; p < 2; p++) begin : g_h
		bsdp_host_model u_h (.clock_i(clock_i), .addr_o(a[p]), .strobe_n_o(s_n[p]), .advance_n_o(c_n[p]),
			.select_o(sel[p]), .lanes_n_o(l_n[p]), .read_o(rw[p]), .wdata_o(wd[p]));
	end
	// Port 1 is pipelined, port 0 flow-through; the strap never moves during the run
	bsdp_dual_port u_bsdp_dual_port (.clock_i(clock_i), .reset_i(reset_i),
		.bank_number_inputs_i({a[1][17:12], a[0][17:12]}), .offset_i({a[1][11:0], a[0][11:0]}),
		.address_strobe_load_n_i(s_n), .counter_advance_enable_n_i(c_n), .counter_reload_n_i(rld_n),
		.chip_select_low_active_n_i(~sel), .chip_select_high_active_i(sel & cs_hi), .byte_lane_enable_n_i(l_n),
		.read_write_i(rw), .output_enable_n_i(oe_n), .output_latency_select_i(2'b10), .data_i(wd),
		.data_o(q), .data_oe_o(qe), .bank_clash_o(clash));
	task automatic results();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic op(input int p, input logic r, sl, s, c, input logic [17:0] ad, input logic [3:0] l, input logic [35:0] d);
		if (p == 1) g_h[1].u_h.cyc(r, sl, s, c, ad, l, d);
		else g_h[0].u_h.cyc(r, sl, s, c, ad, l, d);
	endtask : op
	// First load warms the port up, since a fresh select gives no drive
	task automatic rd(input int p, input logic [17:0] x, y, input logic [35:0] ex, ey);
		op(p, 1, 1, 0, 1, x, 4'h0, '0);
		op(p, 1, 1, 0, 1, x, 4'h0, '0);
		op(p, 1, 1, 0, 1, y, 4'h0, '0);
		repeat (p + 1) @(negedge clock_i);
		chk("data_o", ex, q[p]);
		@(negedge clock_i);
		chk("data_o", ey, q[p]);
		op(p, 1, 1, 1, 1, '0, 4'h0, '0);
		repeat (2) @(negedge clock_i);
		chk("data_o", ey, q[p]);
	endtask : rd
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 1000) begin
			err_total++;
			results();
		end
	end
	initial begin
		repeat (6) @(negedge clock_i);
		reset_i = 1'b0;
		repeat (3) @(negedge clock_i);
		op(0, 0, 1, 0, 1, 18'h00fff, 4'h0, 36'h111111111);
		op(0, 0, 1, 1, 0, '0, 4'h0, 36'h222222222);
		op(0, 0, 1, 0, 1, 18'h3ffff, 4'h0, 36'h333333333);
		op(0, 0, 1, 1, 0, '0, 4'h0, 36'h444444444);
		op(0, 1, 0, 1, 1, '0, 4'h0, '0);
		rd(1, 18'h00fff, 18'h01000, 36'h111111111, 36'h222222222);
		rd(1, 18'h3ffff, 18'h00000, 36'h333333333, 36'h444444444);
		rd(0, 18'h01000, 18'h3ffff, 36'h222222222, 36'h333333333);
		fork
			rd(0, 18'h00000, 18'h3ffff, 36'h444444444, 36'h555555555);
			begin
				op(1, 1, 0, 1, 1, '0, 4'h0, '0);
				op(1, 0, 1, 0, 1, 18'h3ffff, 4'h0, 36'h555555555);
				op(1, 1, 0, 1, 1, '0, 4'h0, '0);
			end
		join
		fork
			op(0, 1, 1, 0, 1, 18'h02000, 4'h0, '0);
			op(1, 1, 1, 0, 1, 18'h02005, 4'h0, '0);
		join
		repeat (4) @(negedge clock_i);
		chk("bank_clash_o", 36'h3, {34'h0, clash});
		op(1, 1, 0, 1, 1, '0, 4'h0, '0);
		op(0, 1, 1, 0, 1, 18'h01000, 4'h4, '0);
		repeat (2) @(negedge clock_i);
		chk("data_oe_o", 36'hff803ffff, qe[0]);
		oe_n[0] = 1'b1;
		#1 chk("data_oe_o", '0, qe[0]);
		@(negedge clock_i);
		oe_n[0] = 1'b0;
		// Advance wraps 3ffff to 0, then reload returns to the last strobe address with no gap
		op(0, 1, 1, 0, 1, 18'h3ffff, 4'h0, '0);
		op(0, 1, 1, 1, 0, '0, 4'h0, '0);
		op(0, 1, 1, 1, 1, '0, 4'h0, '0);
		rld_n[0] = 1'b0;
		chk("data_o", 36'h555555555, q[0]);
		@(negedge clock_i);
		rld_n[0] = 1'b1;
		chk("data_o", 36'h444444444, q[0]);
		@(negedge clock_i);
		chk("data_o", 36'h555555555, q[0]);
		cs_hi[0] = 1'b0;
		repeat (2) @(negedge clock_i);
		chk("data_oe_o", '0, qe[0]);
		cs_hi[0] = 1'b1;
		op(0, 1, 0, 1, 1, '0, 4'h0, '0);
		repeat (3) @(negedge clock_i);
		chk("data_oe_o", '0, qe[0]);
		results();
	end
endmodule : bsdp_dual_port_bench
`default_nettype wire

// [test/bsdp_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bsdp_host_model (
	input	wire logic		clock_i,
	output	var logic [17:0]	addr_o,
	output	var logic		strobe_n_o,
	output	var logic		advance_n_o,
	output	var logic		select_o,
	output	var logic [3:0]		lanes_n_o,
	output	var logic		read_o,
	output	var logic [35:0]	wdata_o
);
	initial begin
		addr_o = '0;
		strobe_n_o = 1'b1;
		advance_n_o = 1'b1;
		select_o = 1'b0;
		lanes_n_o = 4'hf;
		read_o = 1'b1;
		wdata_o = '0;
	end
	// Launched on the falling edge, held a full cycle around the sampling edge
	task automatic cyc(input logic r, sl, s_n, a_n, input logic [17:0] a, input logic [3:0] l, input logic [35:0] d);
		@(negedge clock_i);
		read_o = r;
		select_o = sl;
		strobe_n_o = s_n;
		advance_n_o = a_n;
		addr_o = a;
		lanes_n_o = l;
		wdata_o = r ? ~wdata_o : d; // Released data lines toggle, never hold
	endtask : cyc
endmodule : bsdp_host_model
`default_nettype wire
